/* File: sss_top.sv */
// sss_top: fail-safe sequencing of self tests, reset, init window, watchdog and deep fail-safe
// assumes self-test, supervisor and watchdog-check results arrive as same-clock levels/pulses;
// the key input is a pin and is synchronised here
// Function
// - logic test fault holds reset, deep after 8s
// - logic test runs at start and wake
// - level selection sets supervision thresholds
// - analog test checks detectors and outputs
// - both tests passed releases reset
// - init phase only after tests, no faults
// - init window lasts at most 256 ms
// - init-only configuration locks after init
// - first good refresh enters normal running
// - window period changeable in init, normal
// - leave normal on errors, ext reset, faults
// - reset low delay, release if fault-free
// - reset duration config writable in init only
// - deep on final count or 8s low
// - deep rails off, key cycles low-power
// - final counter value selectable 2 or 6
// - power-up timer from level select to release
// - init phase may disable 8s timer
// - normal: timer restarts per reset assertion
// - report supervisor results, act on faults
// - two active-low outputs, four graded sub-states
// - each reset increments error counter by one
// - intermediate level 1 or 3 asserts failsafe
// - reset low 1 ms or 10 ms, long after wake
`timescale 1ns/100ps
module sss_top #(
  parameter longint unsigned DEEP_TMO_CYC = sss_pkg::DEEP_TMO_CYC,
  parameter longint unsigned INIT_WIN_CYC = sss_pkg::INIT_WIN_CYC,
  parameter longint unsigned RST_LONG_CYC = sss_pkg::RST_LONG_CYC,
  parameter longint unsigned RST_SHORT_CYC = sss_pkg::RST_SHORT_CYC,
  parameter int unsigned WIN_W = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wake,                   // wake event from low-power-off
  input wire logic i_logic_test_done,
  input wire logic i_logic_test_fail,
  input wire logic [1:0] i_level_sel,        // detected rail level selection
  input wire logic i_level_sel_done,
  input wire logic i_analog_test_done,
  input wire logic i_analog_test_fail,
  input wire sss_pkg::sss_sup_t i_sup,
  input wire logic i_ext_reset_req,
  input wire logic i_wd_good,                // one-cycle pulse, correct refresh
  input wire logic i_wd_bad_limit,           // consecutive bad refreshes reached limit
  input wire logic i_cfg_we,
  input wire sss_pkg::sss_cfg_t i_cfg,
  input wire logic i_win_we,
  input wire logic [WIN_W-1:0] i_win_sel,
  input wire logic i_key,                    // key pin, asynchronous
  output logic o_mcu_reset_out_n,
  output logic o_failsafe_out_n,
  output logic o_rails_on,
  output logic o_low_power_off,
  output logic o_safety_init_phase,
  output logic o_wd_running,
  output logic [1:0] o_thr_sel,
  output sss_pkg::sss_sup_t o_sup_report,
  output sss_pkg::sss_cfg_t o_cfg,
  output logic [WIN_W-1:0] o_win_sel,
  output logic [2:0] o_rst_err_cnt,
  output logic o_deep
);
  localparam int TW = 32;
  localparam logic [TW-1:0] DEEP_T = TW'(DEEP_TMO_CYC);
  localparam logic [TW-1:0] INIT_T = TW'(INIT_WIN_CYC);
  localparam logic [TW-1:0] LONG_T = TW'(RST_LONG_CYC);
  localparam logic [TW-1:0] SHORT_T = TW'(RST_SHORT_CYC);

  if (DEEP_TMO_CYC < 2 || DEEP_TMO_CYC > 64'hffff_ffff || INIT_WIN_CYC < 2 ||
      INIT_WIN_CYC > 64'hffff_ffff || RST_SHORT_CYC < 1 || RST_LONG_CYC < RST_SHORT_CYC ||
      RST_LONG_CYC > 64'hffff_ffff || WIN_W < 1) begin : g_bad_params
    $error("sss_top: unusable timing parameters");
  end

  // reset release through two flip-flops
  logic rst_a_r, rst_b_r, rst_n;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end
  assign rst_n = rst_b_r;

  // key synchroniser: updates once second and third stage agree
  logic [2:0] key_sync_r;
  logic key_r, key_nxt;
  always_comb begin
    key_nxt = key_r;
    if (key_sync_r[1] == key_sync_r[2]) key_nxt = key_sync_r[2];
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idles at key on, so no false key-off after reset
      key_sync_r <= 3'h7;
      key_r <= 1'b1;
    end else begin
      key_sync_r <= {key_sync_r[1:0], i_key};
      key_r <= key_nxt;
    end
  end

  function automatic logic [2:0] final_lvl(input logic inter_one);
    final_lvl = inter_one ? sss_pkg::CNT_FINAL_LO : sss_pkg::CNT_FINAL_HI;
  endfunction
  function automatic logic [2:0] inter_lvl(input logic inter_one);
    inter_lvl = inter_one ? sss_pkg::CNT_INTER_LO : sss_pkg::CNT_INTER_HI;
  endfunction

  sss_pkg::sss_state_t st_r, st_nxt;
  sss_pkg::sss_cfg_t cfg_r, cfg_nxt;
  logic [WIN_W-1:0] win_r, win_nxt;
  logic [1:0] thr_r, thr_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;        // init window / reset delay
  logic [TW-1:0] low_r, low_nxt;        // long reset-low timer
  logic low_on_r, low_on_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic long_rst_r, long_rst_nxt;       // next delay uses the long value
  logic rst_out_r, rst_out_nxt;
  logic fs_out_r, fs_out_nxt;
  logic fault;

  assign fault = |i_sup.uv | |i_sup.ov;

  always_comb begin
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    win_nxt = win_r;
    thr_nxt = thr_r;
    tmr_nxt = tmr_r;
    low_nxt = low_r;
    low_on_nxt = low_on_r;
    cnt_nxt = cnt_r;
    long_rst_nxt = long_rst_r;
    rst_out_nxt = rst_out_r;
    fs_out_nxt = fs_out_r;
    if (low_on_r) low_nxt = low_r + TW'(1);
    if (i_win_we && (st_r == sss_pkg::SSS_INIT || st_r == sss_pkg::SSS_NORMAL))
      win_nxt = i_win_sel;
    unique case (st_r)
      sss_pkg::SSS_LOGIC_TEST: begin
        if (i_logic_test_fail) begin
          low_on_nxt = 1'b1;
        end else if (i_logic_test_done) begin
          st_nxt = sss_pkg::SSS_LEVEL_SEL;
          low_on_nxt = 1'b1;
          low_nxt = '0;
        end
      end
      sss_pkg::SSS_LEVEL_SEL: if (i_level_sel_done) begin
        thr_nxt = i_level_sel;
        st_nxt = sss_pkg::SSS_ANALOG_TEST;
      end
      sss_pkg::SSS_ANALOG_TEST: if (i_analog_test_done && !i_analog_test_fail) begin
        st_nxt = sss_pkg::SSS_RELEASE;
      end
      sss_pkg::SSS_RELEASE: if (!fault && !i_ext_reset_req) begin
        rst_out_nxt = 1'b1;
        fs_out_nxt = 1'b1;
        low_on_nxt = 1'b0;
        st_nxt = sss_pkg::SSS_INIT;
        tmr_nxt = '0;
      end
      sss_pkg::SSS_INIT: begin
        tmr_nxt = tmr_r + TW'(1);
        if (i_cfg_we) cfg_nxt = i_cfg;
        if (i_wd_good) begin
          st_nxt = sss_pkg::SSS_NORMAL;
        end else if (fault || i_ext_reset_req || tmr_r >= INIT_T - TW'(1)) begin
          st_nxt = sss_pkg::SSS_RST_DELAY;
        end
      end
      sss_pkg::SSS_NORMAL: if (fault || i_ext_reset_req || i_wd_bad_limit) begin
        st_nxt = sss_pkg::SSS_RST_DELAY;
      end
      sss_pkg::SSS_RST_DELAY: begin
        tmr_nxt = tmr_r + TW'(1);
        if ((long_rst_r || cfg_r.rst_long) ? tmr_r >= LONG_T - TW'(1)
                                           : tmr_r >= SHORT_T - TW'(1)) begin
          if (!fault && !i_ext_reset_req) begin
            rst_out_nxt = 1'b1;
            low_on_nxt = 1'b0;
            long_rst_nxt = 1'b0;
            st_nxt = sss_pkg::SSS_INIT;
            tmr_nxt = '0;
          end
        end
      end
      sss_pkg::SSS_DEEP: if (!key_r) begin
        st_nxt = sss_pkg::SSS_DEEP_OFF;
      end
      sss_pkg::SSS_DEEP_OFF: if (key_r || i_wake) begin
        st_nxt = sss_pkg::SSS_LOGIC_TEST;
        cfg_nxt = {sss_pkg::CFG_RST_LONG_RST, sss_pkg::CFG_INTER_ONE_RST, sss_pkg::CFG_TMR_DIS_RST};
        cnt_nxt = '0;
        long_rst_nxt = 1'b1;
        low_on_nxt = 1'b0;
        low_nxt = '0;
        fs_out_nxt = 1'b0;
      end
    endcase
    // entry into reset: count, restart timer, grade failsafe
    if (st_nxt == sss_pkg::SSS_RST_DELAY && st_r != sss_pkg::SSS_RST_DELAY) begin
      rst_out_nxt = 1'b0;
      tmr_nxt = '0;
      low_nxt = '0;
      low_on_nxt = !cfg_r.tmr_dis;
      if (cnt_r != 3'h7) cnt_nxt = cnt_r + 3'h1;
      if (cnt_nxt >= inter_lvl(cfg_r.inter_one)) fs_out_nxt = 1'b0;
    end
    // deep fail-safe entry
    if (st_r != sss_pkg::SSS_DEEP && st_r != sss_pkg::SSS_DEEP_OFF &&
        (cnt_nxt >= final_lvl(cfg_r.inter_one) ||
         (low_on_r && low_r >= DEEP_T - TW'(1)))) begin
      st_nxt = sss_pkg::SSS_DEEP;
      rst_out_nxt = 1'b0;
      fs_out_nxt = 1'b0;
      low_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sss_pkg::SSS_LOGIC_TEST;
      cfg_r <= {sss_pkg::CFG_RST_LONG_RST, sss_pkg::CFG_INTER_ONE_RST, sss_pkg::CFG_TMR_DIS_RST};
      win_r <= '0;
      thr_r <= 2'h0;
      tmr_r <= '0;
      low_r <= '0;
      low_on_r <= 1'b0;
      cnt_r <= 3'h0;
      long_rst_r <= 1'b1;
      rst_out_r <= 1'b0;
      fs_out_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cfg_r <= cfg_nxt;
      win_r <= win_nxt;
      thr_r <= thr_nxt;
      tmr_r <= tmr_nxt;
      low_r <= low_nxt;
      low_on_r <= low_on_nxt;
      cnt_r <= cnt_nxt;
      long_rst_r <= long_rst_nxt;
      rst_out_r <= rst_out_nxt;
      fs_out_r <= fs_out_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_mcu_reset_out_n <= 1'b0;
      o_failsafe_out_n <= 1'b0;
      o_rails_on <= 1'b1;
      o_low_power_off <= 1'b0;
      o_safety_init_phase <= 1'b0;
      o_wd_running <= 1'b0;
      o_thr_sel <= 2'h0;
      o_sup_report <= '0;
      o_cfg <= {sss_pkg::CFG_RST_LONG_RST, sss_pkg::CFG_INTER_ONE_RST, sss_pkg::CFG_TMR_DIS_RST};
      o_win_sel <= '0;
      o_rst_err_cnt <= 3'h0;
      o_deep <= 1'b0;
    end else begin
      o_mcu_reset_out_n <= rst_out_nxt;
      o_failsafe_out_n <= fs_out_nxt;
      o_rails_on <= !(st_nxt == sss_pkg::SSS_DEEP || st_nxt == sss_pkg::SSS_DEEP_OFF);
      o_low_power_off <= st_nxt == sss_pkg::SSS_DEEP_OFF;
      o_safety_init_phase <= st_nxt == sss_pkg::SSS_INIT;
      o_wd_running <= st_nxt == sss_pkg::SSS_NORMAL;
      o_thr_sel <= thr_nxt;
      o_sup_report <= i_sup;
      o_cfg <= cfg_nxt;
      o_win_sel <= win_nxt;
      o_rst_err_cnt <= cnt_nxt;
      o_deep <= st_nxt == sss_pkg::SSS_DEEP || st_nxt == sss_pkg::SSS_DEEP_OFF;
    end
  end

  a_cfg_lock: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r != sss_pkg::SSS_INIT |=> $stable(cfg_r) || $past(st_r) == sss_pkg::SSS_DEEP_OFF)
    else $error("config changed outside init");
  a_init_exit: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_INIT && i_wd_good && !(cnt_nxt >= final_lvl(cfg_r.inter_one))
    |=> st_r == sss_pkg::SSS_NORMAL)
    else $error("good refresh did not start normal");
  a_init_limit: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_INIT |-> tmr_r < INIT_T)
    else $error("init window overrun");
  a_rst_enter: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_NORMAL && i_ext_reset_req |=> !o_mcu_reset_out_n)
    else $error("reset request ignored");
  a_cnt_step: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_NORMAL ##1 st_r == sss_pkg::SSS_RST_DELAY
    |-> cnt_r == $past(cnt_r) + 3'h1 || $past(cnt_r) == 3'h7)
    else $error("reset count not stepped");
  a_deep_final: assert property (@(posedge i_clk) disable iff (!rst_n)
    cnt_r >= final_lvl(cfg_r.inter_one) |-> o_deep && !o_rails_on)
    else $error("final count without deep");
  a_fs_inter: assert property (@(posedge i_clk) disable iff (!rst_n)
    cnt_r >= inter_lvl(cfg_r.inter_one) && st_r != sss_pkg::SSS_LOGIC_TEST |-> !o_failsafe_out_n)
    else $error("intermediate level without failsafe");
  a_release_ok: assert property (@(posedge i_clk) disable iff (!rst_n)
    $rose(o_mcu_reset_out_n) |-> !$past(fault))
    else $error("reset released under fault");
  a_deep_key: assert property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_DEEP && !key_r |=> st_r == sss_pkg::SSS_DEEP_OFF)
    else $error("key low did not enter low power");
  c_init_done: cover property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_INIT ##1 st_r == sss_pkg::SSS_NORMAL);
  c_rst_cycle: cover property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_RST_DELAY ##1 st_r == sss_pkg::SSS_INIT);
  c_deep: cover property (@(posedge i_clk) disable iff (!rst_n) $rose(o_deep));
  c_wake: cover property (@(posedge i_clk) disable iff (!rst_n)
    st_r == sss_pkg::SSS_DEEP_OFF ##1 st_r == sss_pkg::SSS_LOGIC_TEST);
endmodule // sss_top

/* File: sss_pkg.sv */
// sss_pkg: shared constants and carrier types of the safety state sequencer
// assumes a single 250 MHz clock feeding every timer
package sss_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  // timing figures in their own units
  localparam int unsigned DEEP_TMO_S = 8;
  localparam int unsigned INIT_WIN_MS = 256;
  localparam int unsigned RST_LONG_MS = 10;
  localparam int unsigned RST_SHORT_US = 1000;
  // derived cycle counts
  localparam longint unsigned DEEP_TMO_CYC = longint'(DEEP_TMO_S) * CLK_HZ;
  localparam longint unsigned INIT_WIN_CYC = longint'(INIT_WIN_MS) * (CLK_HZ / 1000);
  localparam longint unsigned RST_LONG_CYC = longint'(RST_LONG_MS) * (CLK_HZ / 1000);
  localparam longint unsigned RST_SHORT_CYC = longint'(RST_SHORT_US) * (CLK_HZ / 1000000);
  // reset error counter levels
  localparam logic [2:0] CNT_INTER_LO = 3'h1;
  localparam logic [2:0] CNT_INTER_HI = 3'h3;
  localparam logic [2:0] CNT_FINAL_LO = 3'h2;
  localparam logic [2:0] CNT_FINAL_HI = 3'h6;
  // reset values of the init-locked configuration
  localparam logic CFG_RST_LONG_RST = 1'b1;
  localparam logic CFG_INTER_ONE_RST = 1'b0;
  localparam logic CFG_TMR_DIS_RST = 1'b0;

  typedef enum {
    SSS_LOGIC_TEST, SSS_LEVEL_SEL, SSS_ANALOG_TEST, SSS_RELEASE,
    SSS_INIT, SSS_NORMAL, SSS_RST_DELAY, SSS_DEEP, SSS_DEEP_OFF
  } sss_state_t;

  // configuration written only during the init phase
  typedef struct packed {
    logic rst_long;   // 1: 10 ms reset low, 0: 1 ms except the first delay after reset or wake
    logic inter_one;  // 1: intermediate level 1 (final 2), 0: level 3 (final 6)
    logic tmr_dis;    // disables the long reset-low timer
  } sss_cfg_t;

  // supervisor results
  typedef struct packed {
    logic [1:0] uv;   // analog, auxiliary rail undervoltage
    logic [1:0] ov;
  } sss_sup_t;
endpackage

/* File: sss_mcu_model.sv */
// sss_mcu_model: host model that configures the sequencer and refreshes its watchdog
// assumes the bench clock; outputs change at the falling edge
`timescale 1ns/100ps
module sss_mcu_model (
  input wire logic i_clk,
  input wire logic i_mcu_reset_out_n,
  input wire logic i_init_phase,
  input wire logic i_running,
  input wire logic i_refresh_en,
  input wire logic i_slow,
  input wire sss_pkg::sss_cfg_t i_cfg_val,
  output logic o_cfg_we,
  output sss_pkg::sss_cfg_t o_cfg,
  output logic o_wd_good
);
  int cnt = 0;
  int t_cfg;
  assign t_cfg = i_slow ? 40 : 2;
  initial begin
    o_cfg_we = 1'b0;
    o_wd_good = 1'b0;
    o_cfg = 3'h0;
  end
  always @(negedge i_clk) begin
    cnt <= i_mcu_reset_out_n ? cnt + 1 : 0;
    o_cfg_we <= i_mcu_reset_out_n && i_init_phase && cnt == t_cfg;
    // bus is not held between writes
    o_cfg <= (cnt == t_cfg) ? i_cfg_val : ~o_cfg;
    o_wd_good <= i_refresh_en && i_mcu_reset_out_n && ((i_init_phase && cnt == t_cfg + 2)
      || (i_running && cnt[3:0] == 4'h0));
  end
endmodule // sss_mcu_model

/* File: sss_top_bench.sv */
// sss_top_bench: self-checking bench of the safety state sequencer with a host model
// assumes shortened timer parameters; inputs change at the falling edge
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(c, n) begin waited = 0; while (!(c) && waited < (n)) begin @(negedge i_clk); waited++; end \
  if (!(c)) begin n_errors++; $display("[FAIL] wait expected 1 seen 0"); conclude(); end end
module sss_top_bench;
  localparam int DT = 200;
  localparam int IW = 100;
  localparam int RL = 20;
  int n_errors = 0;
  int compares = 0;
  int waited = 0;
  int rels = 0;
  int r0 = 0;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_wake = 1'b0, i_key = 1'b1, i_ext_reset_req = 1'b0;
  logic i_logic_test_done = 1'b0, i_logic_test_fail = 1'b0, i_level_sel_done = 1'b0;
  logic i_analog_test_done = 1'b0, i_analog_test_fail = 1'b0, i_wd_bad_limit = 1'b0;
  logic tb_we = 1'b0, i_win_we = 1'b0, refresh_en = 1'b1, slow = 1'b0;
  logic [1:0] i_level_sel = 2'h0;
  logic [3:0] i_win_sel = 4'h0;
  sss_pkg::sss_sup_t i_sup = 4'h0;
  sss_pkg::sss_cfg_t tb_cfg = 3'h0, cfg_val = 3'h2, m_cfg, i_cfg, o_cfg;
  logic m_we, i_cfg_we, i_wd_good, o_mcu_reset_out_n, o_failsafe_out_n, o_rails_on, o_low_power_off;
  logic o_safety_init_phase, o_wd_running, o_deep;
  logic [1:0] o_thr_sel;
  logic [3:0] o_win_sel;
  logic [2:0] o_rst_err_cnt;
  sss_pkg::sss_sup_t o_sup_report;
  assign i_cfg_we = tb_we | m_we;
  assign i_cfg = tb_we ? tb_cfg : m_cfg;

  sss_top #(.DEEP_TMO_CYC(DT), .INIT_WIN_CYC(IW), .RST_LONG_CYC(RL), .RST_SHORT_CYC(5)) sss_top_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wake(i_wake), .i_logic_test_done(i_logic_test_done),
    .i_logic_test_fail(i_logic_test_fail), .i_level_sel(i_level_sel), .i_level_sel_done(i_level_sel_done),
    .i_analog_test_done(i_analog_test_done), .i_analog_test_fail(i_analog_test_fail), .i_sup(i_sup),
    .i_ext_reset_req(i_ext_reset_req), .i_wd_good(i_wd_good), .i_wd_bad_limit(i_wd_bad_limit),
    .i_cfg_we(i_cfg_we), .i_cfg(i_cfg), .i_win_we(i_win_we), .i_win_sel(i_win_sel), .i_key(i_key),
    .o_mcu_reset_out_n(o_mcu_reset_out_n), .o_failsafe_out_n(o_failsafe_out_n), .o_rails_on(o_rails_on),
    .o_low_power_off(o_low_power_off), .o_safety_init_phase(o_safety_init_phase), .o_wd_running(o_wd_running),
    .o_thr_sel(o_thr_sel), .o_sup_report(o_sup_report), .o_cfg(o_cfg), .o_win_sel(o_win_sel),
    .o_rst_err_cnt(o_rst_err_cnt), .o_deep(o_deep));

  sss_mcu_model sss_mcu_model_i (.i_clk(i_clk), .i_mcu_reset_out_n(o_mcu_reset_out_n),
    .i_init_phase(o_safety_init_phase), .i_running(o_wd_running), .i_refresh_en(refresh_en), .i_slow(slow),
    .i_cfg_val(cfg_val), .o_cfg_we(m_we), .o_cfg(m_cfg), .o_wd_good(i_wd_good));

  initial forever #2 i_clk = ~i_clk;
  always @(posedge o_mcu_reset_out_n) rels++;

  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset();
    i_reset_n = 1'b0;
    repeat (6) @(negedge i_clk);
    `CHK("reset out in reset", 1'b0, o_mcu_reset_out_n)
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask

  task automatic self_tests(input logic [1:0] sel);
    `CHK("reset held", 1'b0, o_mcu_reset_out_n)
    i_logic_test_done = 1'b1;
    i_level_sel = sel;
    @(negedge i_clk);
    i_level_sel_done = 1'b1;
    @(negedge i_clk);
    i_analog_test_done = 1'b1;
    `WAITC(o_mcu_reset_out_n === 1'b1, 10)
    `CHK("init phase", 1'b1, o_safety_init_phase)
    `CHK("thresholds", sel, o_thr_sel)
    `CHK("failsafe released", 1'b1, o_failsafe_out_n)
    {i_logic_test_done, i_level_sel_done, i_analog_test_done} = 3'h0;
  endtask

  task automatic t_boot();
    do_reset();
    self_tests(2'h2);
    `WAITC(o_wd_running === 1'b1, 20)
    `CHK("init left", 1'b0, o_safety_init_phase)
    `CHK("cfg taken", cfg_val, o_cfg)
    tb_cfg = 3'h5;
    tb_we = 1'b1;
    i_win_sel = 4'h9;
    i_win_we = 1'b1;
    @(negedge i_clk);
    {tb_we, i_win_we} = 2'h0;
    @(negedge i_clk);
    `CHK("cfg locked", cfg_val, o_cfg)
    `CHK("window set", 4'h9, o_win_sel)
  endtask

  task automatic t_fault();
    i_sup = 4'h2;
    repeat (2) @(negedge i_clk);
    `CHK("sup report", 4'h2, o_sup_report)
    `CHK("reset on fault", 1'b0, o_mcu_reset_out_n)
    `CHK("error count", 3'h1, o_rst_err_cnt)
    `CHK("failsafe at one", 1'b0, o_failsafe_out_n)
    repeat (RL + 5) @(negedge i_clk);
    `CHK("held while fault", 1'b0, o_mcu_reset_out_n)
    i_sup = 4'h0;
    `WAITC(o_mcu_reset_out_n === 1'b1, RL + 5)
    `CHK("init again", 1'b1, o_safety_init_phase)
    `WAITC(o_wd_running === 1'b1, 20)
  endtask

  task automatic t_deep();
    i_wd_bad_limit = 1'b1;
    @(negedge i_clk);
    i_wd_bad_limit = 1'b0;
    @(negedge i_clk);
    `CHK("second count", 3'h2, o_rst_err_cnt)
    `WAITC(o_deep === 1'b1, 10)
    `CHK("rails off", 1'b0, o_rails_on)
    `CHK("deep reset", 1'b0, o_mcu_reset_out_n)
    `CHK("deep failsafe", 1'b0, o_failsafe_out_n)
  endtask

  task automatic t_wake();
    refresh_en = 1'b0;
    slow = 1'b1;
    cfg_val = 3'h0;
    i_key = 1'b0;
    `WAITC(o_low_power_off === 1'b1, 10)
    i_key = 1'b1;
    `WAITC(o_low_power_off === 1'b0, 10)
    `CHK("deep left", 1'b0, o_deep)
    self_tests(2'h1);
    `CHK("cfg default", 3'h4, o_cfg)
    `WAITC(o_mcu_reset_out_n === 1'b0, IW + 10)
    `CHK("window length", 1'b1, waited >= IW - 10)
    `WAITC(o_mcu_reset_out_n === 1'b1, RL + 10)
    `CHK("long delay", 1'b1, waited >= RL - 3)
    refresh_en = 1'b1;
    `WAITC(o_wd_running === 1'b1, 60)
    i_ext_reset_req = 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("ext reset", 1'b0, o_mcu_reset_out_n)
    `CHK("no failsafe below three", 1'b1, o_failsafe_out_n)
    i_ext_reset_req = 1'b0;
  endtask

  task automatic t_test_fail(input logic lbad);
    do_reset();
    r0 = rels;
    i_logic_test_fail = lbad;
    i_analog_test_fail = !lbad;
    {i_logic_test_done, i_level_sel_done, i_analog_test_done} = 3'h7;
    `WAITC(o_deep === 1'b1, DT + 20)
    `CHK("no release", r0, rels)
    `CHK("timer length", 1'b1, waited >= DT - 20)
    {i_logic_test_fail, i_analog_test_fail, i_logic_test_done, i_level_sel_done, i_analog_test_done} = 5'h0;
  endtask

  initial begin
    t_boot();
    t_fault();
    t_deep();
    t_wake();
    t_test_fail(1'b1);
    t_test_fail(1'b0);
    conclude();
  end
endmodule // sss_top_bench
